//--- core/smsw_sync.sv
// module: three-stage pin synchroniser with agreement filter
module smsw_sync (
    // clock, reset, enable
    input wire logic    sys_clk_i,
    input wire logic    sys_rst_i,
    input wire logic    ce_i,
    // pins
    smsw_pin_if.sync    pins
);
    import smsw_pkg::*;

    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic [5:0] clean;
    } smsw_sync_s;

    smsw_sync_s q;
    smsw_sync_s d;
    logic [5:0] diff;

    always_comb begin
        d    = q;
        diff = q.s2 ^ q.s3;
        if (ce_i) begin
            d.s1 = pins.raw;
            d.s2 = q.s1;
            d.s3 = q.s2;
            // a level counts once stages two and three agree
            d.clean = (~diff & q.s3) | (diff & q.clean);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pins.clean = q.clean;

    clean_agree_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ce_i && (q.s2 == q.s3) |=> q.clean == $past(q.s3))
        else $error("clean pin level ignores agreeing stages");
endmodule

//--- core/smsw_top.sv
// module: hybrid control mode switch with shared input pin remapping
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
import smsw_pkg::*;

module smsw_top (
    // clock, reset, enable
    input  wire logic                             sys_clk_i,
    input  wire logic                             sys_rst_i,
    input  wire logic                             ce_i,
    // axi4-lite write address and data
    input  wire logic                             s_axi_awvalid_i,
    output wire logic                             s_axi_awready_o,
    input  wire logic [smsw_pkg::SMSW_ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                             s_axi_wvalid_i,
    output wire logic                             s_axi_wready_o,
    input  wire logic [31:0]                      s_axi_wdata_i,
    input  wire logic [3:0]                       s_axi_wstrb_i,
    // axi4-lite write response
    output wire logic                             s_axi_bvalid_o,
    input  wire logic                             s_axi_bready_i,
    output wire logic [1:0]                       s_axi_bresp_o,
    // axi4-lite read
    input  wire logic                             s_axi_arvalid_i,
    output wire logic                             s_axi_arready_o,
    input  wire logic [smsw_pkg::SMSW_ADDR_W-1:0] s_axi_araddr_i,
    output wire logic                             s_axi_rvalid_o,
    input  wire logic                             s_axi_rready_i,
    output wire logic [31:0]                      s_axi_rdata_o,
    output wire logic [1:0]                       s_axi_rresp_o,
    // digital input pins, high while shorted to signal ground
    input  wire logic                             mode_select_input_i,
    input  wire logic                             position_trigger_input_i,
    input  wire logic [3:0]                       shared_pin_i,
    // zero speed detection from the speed loop
    input  wire logic                             zero_speed_i,
    // active mode
    output wire logic [2:0]                       active_mode_o,
    output wire logic                             mode_pending_o,
    // decoded input functions
    output wire logic                             forward_start_o,
    output wire logic                             reverse_start_o,
    output wire logic                             forward_torque_select_o,
    output wire logic                             reverse_torque_select_o,
    output wire logic                             proportional_gain_switch_o,
    output wire logic                             torque_limit_select_o,
    output wire logic                             point_select_1_o,
    output wire logic                             speed_select_1_o,
    output wire logic                             speed_select_2_o,
    output wire logic                             position_clear_o,
    output wire logic                             position_trigger_o
);
    import smsw_pkg::*;

    typedef struct packed {
        logic [15:0]            cfg;
        smsw_mode_e             mode;
        logic [SMSW_NFUNC-1:0]  func;
        logic                   trg_prev;
        logic                   trig;
        logic                   aw_got;
        logic [SMSW_ADDR_W-1:0] aw_addr;
        logic                   w_got;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } smsw_state_s;

    smsw_state_s q;
    smsw_state_s d;
    smsw_pair_s  pair;
    smsw_mode_e  target;
    logic        pend;
    logic        allow;
    logic        sel;
    logic        trg_rise;
    logic [31:0] stat_word;

    smsw_pin_if pin_bus ();

    assign pin_bus.raw = {shared_pin_i, position_trigger_input_i, mode_select_input_i};

    smsw_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .pins      (pin_bus.sync)
    );

    // decode configuration into a pair of modes
    function automatic smsw_pair_s pair_decode(input logic [15:0] cfg);
        smsw_pair_s p;
        p = '{hybrid: 1'b1, gated: 1'b1, reg_pos: 1'b0,
              off_mode: SMSW_M_POS, on_mode: SMSW_M_SPD};
        case (cfg)
            SMSW_CFG_PLS_SPD: begin
                p.off_mode = SMSW_M_POS;
                p.on_mode  = SMSW_M_SPD;
            end
            SMSW_CFG_PLS_TQ: begin
                p.off_mode = SMSW_M_TRQ;
                p.on_mode  = SMSW_M_POS;
            end
            SMSW_CFG_REG_SPD: begin
                p.reg_pos  = 1'b1;
                p.off_mode = SMSW_M_POS;
                p.on_mode  = SMSW_M_SPD;
            end
            SMSW_CFG_REG_TQ: begin
                p.reg_pos  = 1'b1;
                p.off_mode = SMSW_M_TRQ;
                p.on_mode  = SMSW_M_POS;
            end
            // speed/torque pair switches without speed gating
            SMSW_CFG_SPD_TQ: begin
                p.gated    = 1'b0;
                p.off_mode = SMSW_M_SPD;
                p.on_mode  = SMSW_M_TRQ;
            end
            default: begin
                p.hybrid   = 1'b0;
                p.gated    = 1'b0;
                p.off_mode = SMSW_M_POS;
                p.on_mode  = SMSW_M_POS;
            end
        endcase
        return p;
    endfunction

    // map the four shared pins onto functions of one mode
    function automatic logic [SMSW_NFUNC-1:0] func_map(input smsw_mode_e m,
                                                       input logic [3:0] pin);
        logic [SMSW_NFUNC-1:0] f;
        f = '0;
        case (m)
            SMSW_M_POS: begin
                f[SMSW_F_GAIN]  = pin[0];
                f[SMSW_F_TLIM]  = pin[1];
                f[SMSW_F_PSEL1] = pin[2];
                f[SMSW_F_CLR]   = pin[3];
            end
            SMSW_M_SPD: begin
                f[SMSW_F_FSTART] = pin[0];
                f[SMSW_F_RSTART] = pin[1];
                f[SMSW_F_SSEL2]  = pin[2];
                f[SMSW_F_SSEL1]  = pin[3];
            end
            SMSW_M_TRQ: begin
                f[SMSW_F_RTQ]   = pin[0];
                f[SMSW_F_FTQ]   = pin[1];
                f[SMSW_F_SSEL2] = pin[2];
                f[SMSW_F_SSEL1] = pin[3];
            end
            default: begin
                f = '0;
            end
        endcase
        return f;
    endfunction

    assign sel      = pin_bus.clean[SMSW_PIN_SEL];
    assign pair     = pair_decode(q.cfg);
    // select level picks the mode of the pair
    assign target   = sel ? pair.on_mode : pair.off_mode;
    assign pend     = (target != q.mode);
    // gated pairs wait for zero speed
    assign allow    = !pair.gated || zero_speed_i;
    // trigger acts on its rising edge
    assign trg_rise = pin_bus.clean[SMSW_PIN_TRG] && !q.trg_prev;

    always_comb begin
        stat_word                     = '0;
        stat_word[SMSW_ST_MODE +: 3]  = q.mode;
        stat_word[SMSW_ST_PEND]       = pend;
        stat_word[SMSW_ST_ZERO]       = zero_speed_i;
        stat_word[SMSW_ST_SEL]        = sel;
        stat_word[SMSW_ST_HYB]        = pair.hybrid;
        stat_word[SMSW_ST_RPOS]       = pair.reg_pos;
    end

    always_comb begin
        d = q;
        if (ce_i) begin
            // a refused change stays pending until zero speed
            if (pend && allow) begin
                d.mode = target;
            end
            // shared pins follow the active mode
            // pin a is forward start in speed, reverse torque in torque
            // start and torque direction are cross-paired
            d.func     = func_map(q.mode, pin_bus.clean[SMSW_PIN_D:SMSW_PIN_A]);
            d.trg_prev = pin_bus.clean[SMSW_PIN_TRG];
            d.trig     = trg_rise && (q.mode == SMSW_M_POS) && pair.reg_pos;
            // write address and data in either order
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                d.aw_got  = 1'b1;
                d.aw_addr = s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                d.w_got = 1'b1;
                d.wdata = s_axi_wdata_i;
                d.wstrb = s_axi_wstrb_i;
            end
            if (q.aw_got && q.w_got) begin
                d.aw_got = 1'b0;
                d.w_got  = 1'b0;
                d.bvalid = 1'b1;
                d.bresp  = SMSW_RESP_OKAY;
                case (q.aw_addr)
                    SMSW_CFG_OFF: begin
                        if (q.wstrb[0]) begin
                            d.cfg[7:0] = q.wdata[7:0];
                        end
                        if (q.wstrb[1]) begin
                            d.cfg[15:8] = q.wdata[15:8];
                        end
                    end
                    SMSW_STAT_OFF, SMSW_FUNC_OFF: begin
                        d.bresp = SMSW_RESP_OKAY;
                    end
                    default: begin
                        d.bresp = SMSW_RESP_SLV;
                    end
                endcase
            end
            if (q.bvalid && s_axi_bready_i) begin
                d.bvalid = 1'b0;
            end
            if (q.rvalid && s_axi_rready_i) begin
                d.rvalid = 1'b0;
            end
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                d.rvalid = 1'b1;
                d.rresp  = SMSW_RESP_OKAY;
                case (s_axi_araddr_i)
                    SMSW_CFG_OFF: begin
                        d.rdata = {16'h0000, q.cfg};
                    end
                    SMSW_STAT_OFF: begin
                        d.rdata = stat_word;
                    end
                    SMSW_FUNC_OFF: begin
                        d.rdata = {22'h0, q.func};
                    end
                    default: begin
                        d.rdata = 32'h00000000;
                        d.rresp = SMSW_RESP_SLV;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            q          <= '0;
            q.cfg      <= SMSW_CFG_RST;
            q.mode     <= SMSW_MODE_RST;
            q.func     <= SMSW_FUNC_RST;
            q.bresp    <= SMSW_RESP_OKAY;
            q.rresp    <= SMSW_RESP_OKAY;
        end else begin
            q <= d;
        end
    end

    // bus handshakes
    assign s_axi_awready_o = ce_i && !q.aw_got && !q.bvalid;
    assign s_axi_wready_o  = ce_i && !q.w_got && !q.bvalid;
    assign s_axi_bvalid_o  = q.bvalid;
    assign s_axi_bresp_o   = q.bresp;
    assign s_axi_arready_o = ce_i && !q.rvalid;
    assign s_axi_rvalid_o  = q.rvalid;
    assign s_axi_rdata_o   = q.rdata;
    assign s_axi_rresp_o   = q.rresp;

    // mode and function outputs
    assign active_mode_o              = q.mode;
    assign mode_pending_o             = pend;
    assign forward_start_o            = q.func[SMSW_F_FSTART];
    assign reverse_start_o            = q.func[SMSW_F_RSTART];
    assign forward_torque_select_o    = q.func[SMSW_F_FTQ];
    assign reverse_torque_select_o    = q.func[SMSW_F_RTQ];
    assign proportional_gain_switch_o = q.func[SMSW_F_GAIN];
    assign torque_limit_select_o      = q.func[SMSW_F_TLIM];
    assign point_select_1_o           = q.func[SMSW_F_PSEL1];
    assign speed_select_1_o           = q.func[SMSW_F_SSEL1];
    assign speed_select_2_o           = q.func[SMSW_F_SSEL2];
    assign position_clear_o           = q.func[SMSW_F_CLR];
    assign position_trigger_o         = q.trig;

    mode_onehot_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $onehot(q.mode))
        else $error("active mode is not one of three");

    pulse_torque_map_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ce_i && q.cfg == SMSW_CFG_PLS_TQ && zero_speed_i && !sel |=> q.mode == SMSW_M_TRQ)
        else $error("pulse torque pair select off did not give torque");

    reg_pos_flag_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (q.cfg == SMSW_CFG_REG_SPD || q.cfg == SMSW_CFG_REG_TQ) |-> pair.reg_pos && pair.gated)
        else $error("register position pair decoded wrongly");

    pos_speed_sel_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ce_i && q.cfg == SMSW_CFG_PLS_SPD && zero_speed_i
        |=> q.mode == ($past(sel) ? SMSW_M_SPD : SMSW_M_POS))
        else $error("position speed pair mode does not follow select");

    speed_torque_sel_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ce_i && q.cfg == SMSW_CFG_SPD_TQ
        |=> q.mode == ($past(sel) ? SMSW_M_TRQ : SMSW_M_SPD))
        else $error("speed torque pair mode does not follow select");

    torque_pos_sel_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ce_i && q.cfg == SMSW_CFG_REG_TQ && zero_speed_i && sel |=> q.mode == SMSW_M_POS)
        else $error("torque position pair select on did not give position");

    speed_pin_map_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ce_i && q.mode == SMSW_M_SPD
        |=> forward_start_o == $past(pin_bus.clean[SMSW_PIN_A]) && !reverse_torque_select_o)
        else $error("shared pin not forward start in speed mode");

    torque_pin_map_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ce_i && q.mode == SMSW_M_TRQ
        |=> reverse_torque_select_o == $past(pin_bus.clean[SMSW_PIN_A])
            && !forward_start_o && !proportional_gain_switch_o)
        else $error("shared pin not remapped in torque mode");

    zero_gate_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $changed(q.mode) && $past(pair.gated) |-> $past(zero_speed_i))
        else $error("gated mode change without zero speed");

    hold_pending_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        pend && pair.gated && !zero_speed_i ##1 !zero_speed_i |-> $stable(q.mode))
        else $error("pending mode change applied without zero speed");

    trigger_edge_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ce_i && trg_rise && q.mode == SMSW_M_POS && pair.reg_pos |=> position_trigger_o ##1
        (!ce_i || !position_trigger_o))
        else $error("position trigger pulse wrong");
endmodule

//--- include/smsw_pin_if.sv
// interface: raw and cleaned digital input pins between core and synchroniser
interface smsw_pin_if;
    logic [5:0] raw;
    logic [5:0] clean;
    modport sync (input raw, output clean);
    modport core (output raw, input clean);
endinterface

//--- include/smsw_pkg.sv
// package: constants and types of the servo control mode switch
package smsw_pkg;
    // bus layout
    localparam int unsigned SMSW_ADDR_W    = 8;
    localparam logic [7:0]  SMSW_CFG_OFF   = 8'h00;
    localparam logic [7:0]  SMSW_STAT_OFF  = 8'h04;
    localparam logic [7:0]  SMSW_FUNC_OFF  = 8'h08;
    localparam logic [1:0]  SMSW_RESP_OKAY = 2'h0;
    localparam logic [1:0]  SMSW_RESP_SLV  = 2'h2;
    // control mode configuration values
    localparam logic [15:0] SMSW_CFG_RST     = 16'h0000;
    localparam logic [15:0] SMSW_CFG_PLS_SPD = 16'h1001;
    localparam logic [15:0] SMSW_CFG_SPD_TQ  = 16'h1003;
    localparam logic [15:0] SMSW_CFG_PLS_TQ  = 16'h1005;
    localparam logic [15:0] SMSW_CFG_REG_SPD = 16'h1011;
    localparam logic [15:0] SMSW_CFG_REG_TQ  = 16'h1015;
    // synchronised pin positions
    localparam int unsigned SMSW_NPIN    = 6;
    localparam int unsigned SMSW_PIN_SEL = 0;
    localparam int unsigned SMSW_PIN_TRG = 1;
    localparam int unsigned SMSW_PIN_A   = 2;
    localparam int unsigned SMSW_PIN_B   = 3;
    localparam int unsigned SMSW_PIN_C   = 4;
    localparam int unsigned SMSW_PIN_D   = 5;
    // status word fields
    localparam int unsigned SMSW_ST_MODE = 0;
    localparam int unsigned SMSW_ST_PEND = 3;
    localparam int unsigned SMSW_ST_ZERO = 4;
    localparam int unsigned SMSW_ST_SEL  = 5;
    localparam int unsigned SMSW_ST_HYB  = 6;
    localparam int unsigned SMSW_ST_RPOS = 7;
    // decoded input function positions
    localparam int unsigned SMSW_NFUNC     = 10;
    localparam int unsigned SMSW_F_FSTART  = 0;
    localparam int unsigned SMSW_F_RSTART  = 1;
    localparam int unsigned SMSW_F_FTQ     = 2;
    localparam int unsigned SMSW_F_RTQ     = 3;
    localparam int unsigned SMSW_F_GAIN    = 4;
    localparam int unsigned SMSW_F_TLIM    = 5;
    localparam int unsigned SMSW_F_PSEL1   = 6;
    localparam int unsigned SMSW_F_SSEL1   = 7;
    localparam int unsigned SMSW_F_SSEL2   = 8;
    localparam int unsigned SMSW_F_CLR     = 9;
    localparam logic [9:0]  SMSW_FUNC_RST  = 10'h0;
    // active control loop modes
    typedef enum logic [2:0] {
        SMSW_M_POS = 3'b001,
        SMSW_M_SPD = 3'b010,
        SMSW_M_TRQ = 3'b100
    } smsw_mode_e;
    localparam smsw_mode_e SMSW_MODE_RST = SMSW_M_POS;
    // decoded hybrid pairing
    typedef struct packed {
        logic       hybrid;
        logic       gated;
        logic       reg_pos;
        smsw_mode_e off_mode;
        smsw_mode_e on_mode;
    } smsw_pair_s;
endpackage

//--- sim/smsw_host_model.sv
// model: host controller driving the digital input pins of the drive
module smsw_host_model (
    // clock
    input  wire logic       sys_clk_i,
    // pin levels requested by the bench
    input  wire logic       sel_i,
    input  wire logic       trg_i,
    input  wire logic [3:0] pin_i,
    // pins toward the drive, high while shorted to ground
    output logic            mode_select_input_o,
    output logic            position_trigger_input_o,
    output logic [3:0]      shared_pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // requested pin levels reach the drive one clock edge later
    always_ff @(posedge sys_clk_i) begin
        mode_select_input_o <= sel_i;
        position_trigger_input_o <= trg_i;
        shared_pin_o <= pin_i;
    end
endmodule

//--- sim/smsw_top_tb.sv
// bench: register and pin level tests of the control mode switch
module smsw_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import smsw_pkg::*;
    logic        clk = 0;
    logic        rst = 1;
    logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, d, rdata;
    logic [1:0]  r, bresp, rresp;
    logic        awr, wr_r, bv, arr, rv, ms, tpin, pend, pto;
    logic        sel = 0, trg = 0, zs = 0, ce = 1;
    logic [3:0]  pin = 0, sp;
    logic [2:0]  mode;
    logic [9:0]  f;
    int          num_errors = 0, checks = 0, npulse = 0;
    logic [15:0] cfg_t [5] = '{SMSW_CFG_PLS_SPD, SMSW_CFG_PLS_TQ, SMSW_CFG_REG_SPD,
                               SMSW_CFG_REG_TQ, SMSW_CFG_SPD_TQ};
    smsw_mode_e  off_t [5] = '{SMSW_M_POS, SMSW_M_TRQ, SMSW_M_POS, SMSW_M_TRQ, SMSW_M_SPD};
    smsw_mode_e  on_t  [5] = '{SMSW_M_SPD, SMSW_M_POS, SMSW_M_SPD, SMSW_M_POS, SMSW_M_TRQ};
    always #50 clk = ~clk;
    always @(negedge clk) if (pto === 1'b1) npulse++;
    smsw_top dut (
        .sys_clk_i(clk), .sys_rst_i(rst), .ce_i(ce),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_bresp_o(bresp),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .mode_select_input_i(ms), .position_trigger_input_i(tpin), .shared_pin_i(sp),
        .zero_speed_i(zs), .active_mode_o(mode), .mode_pending_o(pend),
        .forward_start_o(f[0]), .reverse_start_o(f[1]), .forward_torque_select_o(f[2]),
        .reverse_torque_select_o(f[3]), .proportional_gain_switch_o(f[4]),
        .torque_limit_select_o(f[5]), .point_select_1_o(f[6]), .speed_select_1_o(f[7]),
        .speed_select_2_o(f[8]), .position_clear_o(f[9]), .position_trigger_o(pto));
    smsw_host_model host (.sys_clk_i(clk), .sel_i(sel), .trg_i(trg), .pin_i(pin),
        .mode_select_input_o(ms), .position_trigger_input_o(tpin), .shared_pin_o(sp));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] fb(input int a, input int b);
        return (32'h1 << a) | (32'h1 << b);
    endfunction
    // one bus transfer, write when w is high, result left in d and r
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        @(posedge clk);
        if (w) begin
            {awv, wv, br} <= 3'h7;
            awa <= a;
            wd <= v;
        end else begin
            {arv, rr} <= 2'h3;
            ara <= a;
        end
        forever begin
            @(negedge clk);
            ta = (awv & awr) | (arv & arr);
            tw = wv & wr_r;
            tb = (bv & br) | (rv & rr);
            r = w ? bresp : rresp;
            d = rdata;
            @(posedge clk);
            if (ta) {awv, arv} <= 2'h0;
            if (tw) wv <= 0;
            if (tb) begin
                {br, rr} <= 2'h0;
                break;
            end
        end
    endtask
    // set pins and zero speed, then let sync, mode and functions settle
    task automatic hold(input logic s, input logic t, input logic z, input logic [3:0] p);
        @(posedge clk);
        sel <= s;
        trg <= t;
        zs <= z;
        pin <= p;
        repeat (10) @(posedge clk);
        #10;
    endtask
    task automatic conclude();
        if (num_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        xfer(0, SMSW_CFG_OFF, 0);
        cmp(d, 0);
        cmp(mode, SMSW_M_POS);
        xfer(0, 8'hfc, 0);
        cmp(r, SMSW_RESP_SLV);
        xfer(1, 8'h40, 32'h1001);
        cmp(r, SMSW_RESP_SLV);
        for (int i = 0; i < 5; i++) begin
            xfer(1, SMSW_CFG_OFF, {16'h0, cfg_t[i]});
            cmp(r, SMSW_RESP_OKAY);
            hold(0, 0, 1, 4'h0);
            cmp(mode, off_t[i]);
            hold(1, 0, 1, 4'h0);
            cmp(mode, on_t[i]);
        end
        hold(0, 0, 1, 4'h3);
        xfer(0, SMSW_FUNC_OFF, 0);
        cmp(d, fb(SMSW_F_FSTART, SMSW_F_RSTART));
        cmp(f, fb(SMSW_F_FSTART, SMSW_F_RSTART));
        hold(1, 0, 1, 4'h3);
        xfer(0, SMSW_FUNC_OFF, 0);
        cmp(d, fb(SMSW_F_RTQ, SMSW_F_FTQ));
        cmp(f, fb(SMSW_F_RTQ, SMSW_F_FTQ));
        cmp(f[3], 1);
        hold(1, 0, 1, 4'hc);
        cmp(f, fb(SMSW_F_SSEL2, SMSW_F_SSEL1));
        // clock enable low freezes mode and functions
        @(posedge clk);
        ce <= 0;
        hold(0, 0, 1, 4'h3);
        cmp(mode, SMSW_M_TRQ);
        cmp(f, fb(SMSW_F_SSEL2, SMSW_F_SSEL1));
        @(posedge clk);
        ce <= 1;
        hold(0, 0, 1, 4'h3);
        cmp(mode, SMSW_M_SPD);
        for (int j = 0; j < 2; j++) begin
            xfer(1, SMSW_CFG_OFF, {16'h0, cfg_t[j]});
            hold(0, 0, 1, 4'h3);
            hold(1, 0, 0, 4'h3);
            cmp(mode, off_t[j]);
            cmp(pend, 1);
            hold(1, 0, 1, 4'h3);
            cmp(mode, on_t[j]);
        end
        xfer(0, SMSW_FUNC_OFF, 0);
        cmp(d, fb(SMSW_F_GAIN, SMSW_F_TLIM));
        cmp(f, fb(SMSW_F_GAIN, SMSW_F_TLIM));
        hold(1, 0, 1, 4'hc);
        cmp(f, fb(SMSW_F_PSEL1, SMSW_F_CLR));
        xfer(1, SMSW_CFG_OFF, {16'h0, SMSW_CFG_REG_TQ});
        hold(1, 0, 1, 4'h0);
        hold(1, 1, 1, 4'h0);
        hold(1, 1, 1, 4'h0);
        cmp(npulse, 1);
        xfer(0, SMSW_STAT_OFF, 0);
        cmp(d, 32'h0000_00f1);
        conclude();
    end
endmodule
